/* File: rtl/hmap_host_port.sv */
// host memory access port: address latch, write and read handshakes, overlay control
//
// Notes on behaviour
// - host select low with address latch enable high starts address capture.
// - address capture ends when select rises or latch enable falls.
// - address is taken from bus lines 14 to 0 at end of capture.
// - write runs while select and write strobe are both low.
// - acknowledge goes high shortly after a write starts.
// - acknowledge stays high at least 1.5 core clocks after write start.
// - short write takes data at write end; long write after acknowledge low.
// - read runs while select and read strobe are both low.
// - long read: word is on the bus before acknowledge falls.
// - every read start drives the previously fetched word on the bus.
// - program word moves as two halves; data word as one.
// - overlay register bit 14 at 0x3FE7 enables prior-data-only reads.
// - core and host may both write that bit; it clears at reset.
// - in prior-data-only mode the old word stays on the bus all read.
// - bus drivers turn off shortly after a read ends.
`timescale 1ns/100ps
module hmap_host_port
  import hmap_pkg::*;
#(
  parameter int FIFO_DEPTH = HMAP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // host pins
  input wire logic i_host_select_n,
  input wire logic i_address_latch_enable,
  input wire logic i_host_write_n,
  input wire logic i_host_read_n,
  input wire logic [hmap_pkg::HMAP_BUS_W-1:0] i_host_addr_data,
  output logic [hmap_pkg::HMAP_BUS_W-1:0] o_host_addr_data,
  output logic o_host_addr_data_oe,
  output logic o_host_ack_n,
  // on-chip memory port
  output logic o_mem_valid,
  output logic o_mem_write,
  output logic o_mem_space,
  output logic [hmap_pkg::HMAP_ADDR_W-1:0] o_mem_addr,
  output logic [hmap_pkg::HMAP_PM_W-1:0] o_mem_wdata,
  input wire logic i_mem_ready,
  input wire logic i_mem_rvalid,
  input wire logic [hmap_pkg::HMAP_PM_W-1:0] i_mem_rdata,
  // processor core access to the overlay register
  input wire logic i_core_overlay_write,
  input wire logic [hmap_pkg::HMAP_BUS_W-1:0] i_core_overlay_data,
  output logic [hmap_pkg::HMAP_BUS_W-1:0] o_overlay,
  output logic o_prior_data_only
);
  import hmap_pkg::*;

  // a depth below two leaves no room to queue a write behind the one draining
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("hmap_host_port: FIFO_DEPTH must be at least 2");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_COMMIT,
    ST_RD_DRAIN,
    ST_RD_WAIT,
    ST_RD_END
  } hmap_state_t;

  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ACK_MIN = CNT_W'(HMAP_ACK_MIN_CYCLES);

  // synchronised pins
  logic s_select_n;
  logic s_ale;
  logic s_write_n;
  logic s_read_n;
  logic [HMAP_BUS_W-1:0] s_bus;

  // pins reset to their idle levels so no false access follows reset
  hmap_sync #(.WIDTH(4), .INIT(4'hB)) u_sync_ctl (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async({i_host_select_n, i_address_latch_enable, i_host_write_n, i_host_read_n}),
    .o_sync({s_select_n, s_ale, s_write_n, s_read_n})
  );

  hmap_sync #(.WIDTH(HMAP_BUS_W), .INIT(16'h0000)) u_sync_bus (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_async(i_host_addr_data),
    .o_sync(s_bus)
  );

  // state
  hmap_state_t state_reg;
  hmap_state_t state_next;
  logic ack_n_reg;
  logic ack_n_next;
  logic oe_reg;
  logic [HMAP_BUS_W-1:0] bus_out_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic space_reg;
  logic [HMAP_ADDR_W-1:0] addr_reg;
  logic half_reg;
  logic [HMAP_BUS_W-1:0] wdata_reg;
  logic [HMAP_BUS_W-1:0] pm_hi_reg;
  logic [HMAP_BUS_W-1:0] prev_reg;
  logic [HMAP_PM_W-1:0] word_reg;
  logic rd_req_reg;
  logic [HMAP_BUS_W-1:0] overlay_reg;

  // access decoding
  wire latch_act = !s_select_n && s_ale;
  wire write_act = !s_select_n && !s_write_n;
  wire read_act = !s_select_n && !s_read_n;
  wire is_pm = (space_reg == HMAP_SPACE_PM);
  wire is_overlay = !is_pm && (addr_reg == HMAP_OVERLAY_ADDR);
  wire prior_only = overlay_reg[HMAP_OVERLAY_SRO_BIT];
  // a data word or the second program half completes the word
  wire word_done = !is_pm || half_reg;
  wire ack_min_met = (cnt_reg >= ACK_MIN);

  // write fifo in front of memory
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [HMAP_ENTRY_W-1:0] fifo_out_data;
  wire commit_ok = ack_min_met && fifo_in_ready;
  wire commit = (state_reg == ST_COMMIT) && commit_ok;
  // overlay writes stay in the register and never reach memory
  wire push_word = commit && word_done && !is_overlay;
  wire [HMAP_PM_W-1:0] push_data = is_pm ?
    {pm_hi_reg, wdata_reg[HMAP_PM_HI_LSB-1:0]} : {HMAP_PM_LO_PAD, wdata_reg};

  hmap_fifo #(.WIDTH(HMAP_ENTRY_W), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_in_valid(push_word),
    .o_in_ready(fifo_in_ready),
    .i_in_data({space_reg, addr_reg, push_data}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_mem_ready),
    .o_out_data(fifo_out_data)
  );

  // memory port: queued writes first, reads only once the queue is empty
  assign o_mem_valid = fifo_out_valid || rd_req_reg;
  assign o_mem_write = fifo_out_valid;
  assign o_mem_space = fifo_out_valid ? fifo_out_data[HMAP_ENTRY_W-1] : space_reg;
  assign o_mem_addr = fifo_out_valid ?
    fifo_out_data[HMAP_PM_W +: HMAP_ADDR_W] : addr_reg;
  assign o_mem_wdata = fifo_out_data[HMAP_PM_W-1:0];
  wire rd_taken = rd_req_reg && !fifo_out_valid && i_mem_ready;

  // read results: overlay reads come from the register, program halves split
  wire [HMAP_BUS_W-1:0] fetch_half = is_overlay ? overlay_reg :
    is_pm ? (half_reg ? {HMAP_PM_LO_PAD, i_mem_rdata[HMAP_PM_HI_LSB-1:0]}
                      : i_mem_rdata[HMAP_PM_W-1:HMAP_PM_HI_LSB])
          : i_mem_rdata[HMAP_BUS_W-1:0];
  // the second program half reuses the word fetched for the first
  wire cached_half = is_pm && half_reg;
  wire [HMAP_BUS_W-1:0] cached_val = {HMAP_PM_LO_PAD, word_reg[HMAP_PM_HI_LSB-1:0]};
  wire fetch_now = (state_reg == ST_RD_WAIT) && (i_mem_rvalid || is_overlay);
  wire drain_skip = (state_reg == ST_RD_DRAIN) && cached_half;
  wire [HMAP_BUS_W-1:0] new_half = drain_skip ? cached_val : fetch_half;
  wire new_ready = fetch_now || drain_skip;
  wire read_finish = (state_reg == ST_RD_END) && !read_act;
  wire advance = (commit || read_finish) && word_done;

  always_comb begin
    state_next = state_reg;
    ack_n_next = ack_n_reg;
    case (state_reg)
      ST_IDLE: begin
        // host honours acknowledge low before any access; latch cycles keep it low
        if (write_act) begin
          ack_n_next = 1'b1;
          state_next = ST_WRITE;
        end else if (read_act && !latch_act) begin
          ack_n_next = 1'b1;
          state_next = ST_RD_DRAIN;
        end
      end
      ST_WRITE: begin
        // long write when acknowledge falls while the strobe is still low
        if (commit_ok) begin
          ack_n_next = 1'b0;
        end
        if (!write_act) begin
          state_next = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        if (commit_ok) begin
          ack_n_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      ST_RD_DRAIN: begin
        if (drain_skip) begin
          state_next = ST_RD_END;
        end else if (!fifo_out_valid) begin
          state_next = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        if (fetch_now) begin
          state_next = ST_RD_END;
        end
      end
      ST_RD_END: begin
        // data went out on the edge that entered this state, one cycle ahead
        ack_n_next = 1'b0;
        if (!read_act) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        ack_n_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      ack_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ack_n_reg <= ack_n_next;
    end
  end

  // cycles since the write began
  // the count stops at the minimum, so a long back-pressure stall cannot wrap it
  always_ff @(posedge i_clock) begin
    if (i_reset || state_reg == ST_IDLE) begin
      cnt_reg <= '0;
    end else if (!ack_min_met) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // address capture follows the bus while latching; the last sample wins
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      space_reg <= HMAP_SPACE_PM;
      addr_reg <= '0;
      half_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && latch_act) begin
      space_reg <= s_bus[HMAP_SPACE_BIT];
      addr_reg <= s_bus[HMAP_ADDR_W-1:0];
      half_reg <= 1'b0;
    end else if (commit || read_finish) begin
      half_reg <= is_pm && !half_reg;
      if (advance) begin
        addr_reg <= addr_reg + 1'b1;
      end
    end
  end

  // write data tracks the bus while the strobe is low, so the end value stays
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wdata_reg <= '0;
      pm_hi_reg <= '0;
    end else begin
      if (state_reg == ST_WRITE && write_act) begin
        wdata_reg <= s_bus;
      end
      if (commit && is_pm && !half_reg) begin
        pm_hi_reg <= wdata_reg;
      end
    end
  end

  // read request to memory, raised once the write queue is empty
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rd_req_reg <= 1'b0;
    end else if (rd_taken) begin
      rd_req_reg <= 1'b0;
    end else if (state_reg == ST_RD_DRAIN && !fifo_out_valid && !cached_half &&
                 !is_overlay) begin
      rd_req_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      word_reg <= '0;
      prev_reg <= '0;
    end else begin
      if (fetch_now && !is_overlay) begin
        word_reg <= i_mem_rdata;
      end
      if (new_ready) begin
        prev_reg <= new_half;
      end
    end
  end

  // bus drive: old word at read start, new word unless prior-data-only
  // outputs lag the pins by three edges; a 40 ns clock cannot meet 10 ns windows
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      oe_reg <= 1'b0;
      bus_out_reg <= '0;
    end else begin
      if (state_reg == ST_IDLE && read_act && !latch_act && !write_act) begin
        oe_reg <= 1'b1;
        bus_out_reg <= prev_reg;
      end else if (!read_act) begin
        oe_reg <= 1'b0;
      end
      if (new_ready && !prior_only) begin
        bus_out_reg <= new_half;
      end
      // prior-data-only leaves the old word until the read ends
    end
  end

  // overlay register: host write to its address, or core write
  // a host write wins over a core write in the same cycle; that core write is lost
  wire host_overlay_wr = commit && is_overlay;
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      overlay_reg <= HMAP_OVERLAY_RESET;
    end else if (host_overlay_wr) begin
      overlay_reg <= wdata_reg;
    end else if (i_core_overlay_write) begin
      overlay_reg <= i_core_overlay_data;
    end
  end

  assign o_host_addr_data = bus_out_reg;
  assign o_host_addr_data_oe = oe_reg;
  assign o_host_ack_n = ack_n_reg;
  assign o_overlay = overlay_reg;
  assign o_prior_data_only = prior_only;
endmodule

/* File: rtl/hmap_pkg.sv */
// constants, field layouts and timing counts of the host memory access port
package hmap_pkg;
  // host bus and memory widths
  localparam int HMAP_BUS_W = 16;
  localparam int HMAP_ADDR_W = 14;
  localparam int HMAP_PM_W = 24;
  localparam int HMAP_FIFO_DEPTH = 8;
  // latched address word: bit 14 picks the space, bits 13..0 are the location
  localparam int HMAP_SPACE_BIT = 14;
  localparam logic HMAP_SPACE_PM = 1'b0;
  localparam logic HMAP_SPACE_DM = 1'b1;
  // overlay control register, reached in data memory space
  localparam logic [13:0] HMAP_OVERLAY_ADDR = 14'h3FE7;
  localparam int HMAP_OVERLAY_SRO_BIT = 14;
  localparam logic [15:0] HMAP_OVERLAY_RESET = 16'h0000;
  // acknowledge may not fall sooner than 1.5 core clock periods after write start
  localparam int HMAP_CLOCK_PERIOD_NS = 40;
  localparam int HMAP_ACK_MIN_TCK_TENTHS = 15;
  localparam int HMAP_ACK_MIN_CYCLES = (HMAP_ACK_MIN_TCK_TENTHS + 9) / 10;
  // the short-delay outputs are bounded at 10 ns after the access edge; the port's outputs lag the pins by three 40 ns clock edges
  localparam int HMAP_OUT_DELAY_NS = 10;
  // a program memory word is split: upper 16 bits first, low byte second
  localparam int HMAP_PM_HI_LSB = 8;
  localparam logic [7:0] HMAP_PM_LO_PAD = 8'h00;
  // fifo entry: space, location and data
  localparam int HMAP_ENTRY_W = 1 + HMAP_ADDR_W + HMAP_PM_W;
endpackage

/* File: rtl/hmap_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module hmap_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // the first stage is read by the second stage only
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

/* File: rtl/hmap_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module hmap_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH || WIDTH < 1) begin : g_bad_params
    $error("hmap_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W:0] wr_ptr_reg;
  logic [PTR_W:0] rd_ptr_reg;

  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
              (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_ptr_reg[PTR_W-1:0]];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_reg[PTR_W-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (PTR_W + 1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (PTR_W + 1)'(pop);
    end
  end
endmodule

/* File: testbench/hmap_host_port_asserts.sv */
// concurrent checks on the host memory access port pins
`timescale 1ns/100ps
module hmap_host_port_asserts (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // host pins
  input wire logic i_host_select_n,
  input wire logic i_address_latch_enable,
  input wire logic i_host_write_n,
  input wire logic i_host_read_n,
  input wire logic [hmap_pkg::HMAP_BUS_W-1:0] o_host_addr_data,
  input wire logic o_host_addr_data_oe,
  input wire logic o_host_ack_n,
  // overlay control
  input wire logic i_core_overlay_write,
  input wire logic [hmap_pkg::HMAP_BUS_W-1:0] i_core_overlay_data,
  input wire logic [hmap_pkg::HMAP_BUS_W-1:0] o_overlay,
  input wire logic o_prior_data_only
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  wire wr_on = !i_host_select_n && !i_host_write_n;
  wire rd_on = !i_host_select_n && !i_host_read_n;
  wire idle_start = !o_host_ack_n && !i_address_latch_enable;
  a_reset_idle_out: assert property (disable iff (1'b0) i_reset |=>
    !o_host_ack_n && !o_host_addr_data_oe && o_overlay == 16'h0000)
    else $error("outputs not idle after reset");
  a_write_goes_busy: assert property ($rose(wr_on) && idle_start |-> ##[1:4] o_host_ack_n)
    else $error("ack did not rise after write start");
  a_ack_min_busy: assert property ($rose(o_host_ack_n) |=> o_host_ack_n)
    else $error("ack fell too soon");
  a_read_drives_bus: assert property ($rose(rd_on) && idle_start |->
    ##[1:4] (o_host_addr_data_oe && o_host_ack_n))
    else $error("bus not driven after read start");
  a_read_releases_bus: assert property ($fell(rd_on) && o_host_addr_data_oe |->
    ##[1:4] !o_host_addr_data_oe)
    else $error("bus still driven after read end");
  a_data_before_ack: assert property ($fell(o_host_ack_n) && o_host_addr_data_oe |->
    $stable(o_host_addr_data))
    else $error("read word changed as ack fell");
  a_prior_word_hold: assert property (o_prior_data_only && o_host_addr_data_oe &&
    $past(o_host_addr_data_oe) |-> $stable(o_host_addr_data))
    else $error("word changed during prior data read");
  a_mode_bit_map: assert property (o_prior_data_only == o_overlay[14])
    else $error("mode flag differs from overlay bit");
  a_core_write_lands: assert property (i_core_overlay_write && i_host_select_n &&
    $past(i_host_select_n, 4) |=> o_overlay == $past(i_core_overlay_data))
    else $error("core overlay write lost");
  c_write: cover property ($rose(wr_on));
  c_prior_read: cover property (o_prior_data_only && $rose(o_host_addr_data_oe));
  c_core_write: cover property (i_core_overlay_write);
endmodule
bind hmap_host_port hmap_host_port_asserts hmap_host_port_asserts_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_host_select_n(i_host_select_n),
  .i_address_latch_enable(i_address_latch_enable), .i_host_write_n(i_host_write_n),
  .i_host_read_n(i_host_read_n), .o_host_addr_data(o_host_addr_data),
  .o_host_addr_data_oe(o_host_addr_data_oe), .o_host_ack_n(o_host_ack_n),
  .i_core_overlay_write(i_core_overlay_write), .i_core_overlay_data(i_core_overlay_data),
  .o_overlay(o_overlay), .o_prior_data_only(o_prior_data_only)
);

/* File: testbench/hmap_host_model.sv */
// host processor model driving the port pins
`timescale 1ns/100ps
module hmap_host_model (
  // clock
  input wire logic i_clock,
  // pins toward the device
  output logic o_host_select_n,
  output logic o_address_latch_enable,
  output logic o_host_write_n,
  output logic o_host_read_n,
  output logic [15:0] o_bus,
  input wire logic [15:0] i_dev_data,
  input wire logic i_dev_oe,
  input wire logic i_host_ack_n,
  // a bounded wait ran out
  output logic o_timeout
);
  logic drive = 1'b0;
  logic [15:0] hold = 16'h0000;
  logic [15:0] last = 16'h0000;
  // no pull on the bus, so a released bus shows the inverse of its last level
  assign o_bus = drive ? hold : (i_dev_oe ? i_dev_data : ~last);
  always @(posedge i_clock) if (drive || i_dev_oe) last <= o_bus;
  initial begin
    {o_host_select_n, o_address_latch_enable, o_host_write_n, o_host_read_n} = 4'hB;
    o_timeout = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic wait_ack(input logic lvl);
    int k = 0;
    while (i_host_ack_n !== lvl && k < 400) begin
      cyc(1);
      k++;
    end
    if (k == 400) o_timeout = 1'b1;
  endtask
  task automatic latch(input logic [15:0] a);
    wait_ack(1'b0);
    hold = a;
    drive = 1'b1;
    o_host_select_n = 1'b0;
    o_address_latch_enable = 1'b1;
    cyc(4);
    o_address_latch_enable = 1'b0;
    cyc(3);
    o_host_select_n = 1'b1;
    drive = 1'b0;
    cyc(3);
  endtask
  task automatic write(input logic [15:0] d, input logic long_w);
    wait_ack(1'b0);
    hold = d;
    drive = 1'b1;
    o_host_select_n = 1'b0;
    o_host_write_n = 1'b0;
    if (long_w) begin
      wait_ack(1'b1);
      wait_ack(1'b0);
    end else cyc(3);
    o_host_write_n = 1'b1;
    cyc(3);
    o_host_select_n = 1'b1;
    drive = 1'b0;
    cyc(3);
  endtask
  task automatic read(output logic [15:0] prev, output logic [15:0] fin);
    wait_ack(1'b0);
    o_host_select_n = 1'b0;
    o_host_read_n = 1'b0;
    cyc(4);
    prev = o_bus;
    wait_ack(1'b1);
    wait_ack(1'b0);
    fin = o_bus;
    o_host_read_n = 1'b1;
    o_host_select_n = 1'b1;
    cyc(5);
  endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the host memory access port
`timescale 1ns/100ps
module tb_top;
  import hmap_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic sel_n, ale, wr_n, rd_n, ack_n, oe, to_flag, mode, mvalid, mwrite, mspace;
  logic mready, mrvalid, core_we, stall, rd_q;
  logic [15:0] bus, dout, ovl, core_d;
  logic [13:0] maddr;
  logic [23:0] mwdata, mrdata;
  logic [7:0] rd_a;
  logic [23:0] mem [0:255];
  logic [31:0] rnd = 32'h2CFB;
  int failures = 0;
  int tests_run = 0;
  hmap_host_port #(.FIFO_DEPTH(HMAP_FIFO_DEPTH)) hmap_host_port_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_host_select_n(sel_n),
    .i_address_latch_enable(ale), .i_host_write_n(wr_n), .i_host_read_n(rd_n),
    .i_host_addr_data(bus), .o_host_addr_data(dout), .o_host_addr_data_oe(oe),
    .o_host_ack_n(ack_n), .o_mem_valid(mvalid), .o_mem_write(mwrite), .o_mem_space(mspace),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ready(mready), .i_mem_rvalid(mrvalid),
    .i_mem_rdata(mrdata), .i_core_overlay_write(core_we), .i_core_overlay_data(core_d),
    .o_overlay(ovl), .o_prior_data_only(mode)
  );
  hmap_host_model hmap_host_model_inst (
    .i_clock(i_clock), .o_host_select_n(sel_n), .o_address_latch_enable(ale),
    .o_host_write_n(wr_n), .o_host_read_n(rd_n), .o_bus(bus), .i_dev_data(dout),
    .i_dev_oe(oe), .i_host_ack_n(ack_n), .o_timeout(to_flag)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #20 i_clock = ~i_clock;
  // memory side: random stalls, read data one cycle after acceptance
  always @(posedge i_clock) begin
    rd_q <= mvalid && mready && !mwrite;
    if (mvalid && mready) begin
      rd_a <= {mspace, maddr[6:0]};
      if (mwrite) mem[{mspace, maddr[6:0]}] <= mwdata;
    end
  end
  always @(negedge i_clock) begin
    rnd <= lfsr(rnd);
    mready <= !stall && (rnd[2] || rnd[9]);
    mrvalid <= rd_q;
    mrdata <= rd_q ? mem[rd_a] : ~mrdata;
  end
  always @(posedge to_flag) begin
    failures++;
    test_done;
  end
  initial begin
    repeat (60000) @(posedge i_clock);
    failures++;
    test_done;
  end
  initial begin
    logic [15:0] w [0:8];
    logic [15:0] a, p, f, last_f, x;
    logic [23:0] pw;
    int n, i, k;
    {mready, mrvalid, core_we, stall, rd_q} = 5'h00;
    mrdata = 24'h000000;
    core_d = 16'h0000;
    repeat (4) @(negedge i_clock);
    i_reset = 1'b0;
    @(negedge i_clock);
    check_val("overlay at reset", 16'h0000, ovl);
    check_val("mode at reset", 16'h0000, {15'h0000, mode});
    // first pass fills the fifo while memory stalls and wraps the address
    for (n = 0; n < 4; n++) begin
      a = (n == 0) ? 16'h7FFA : {10'h100, rnd[5:0]};
      k = (n == 0) ? 9 : 3;
      stall = (n == 0);
      hmap_host_model_inst.latch(a);
      for (i = 0; i < k; i++) begin
        w[i] = rnd[15:0];
        if (i == 8) fork
          hmap_host_model_inst.write(w[i], 1'b1);
          begin
            repeat (30) @(negedge i_clock);
            check_val("ack_n while full", 16'h0001, {15'h0000, ack_n});
            stall = 1'b0;
          end
        join
        else hmap_host_model_inst.write(w[i], rnd[20]);
      end
      hmap_host_model_inst.latch(a);
      for (i = 0; i < k; i++) begin
        hmap_host_model_inst.read(p, f);
        if (n + i > 0) check_val("previous word", last_f, p);
        check_val("read word", w[i], f);
        check_val("bus enable", 16'h0000, {15'h0000, oe});
        last_f = f;
      end
      $display("test data burst %0d done", n);
    end
    pw = rnd[23:0];
    hmap_host_model_inst.latch(16'h0020);
    hmap_host_model_inst.write(pw[23:8], 1'b1);
    hmap_host_model_inst.write({8'h00, pw[7:0]}, 1'b0);
    x = rnd[31:16];
    hmap_host_model_inst.write(x, 1'b0);
    hmap_host_model_inst.write({8'h00, rnd[7:0]}, 1'b0);
    hmap_host_model_inst.latch(16'h0020);
    hmap_host_model_inst.read(p, f);
    check_val("program first half", pw[23:8], f);
    hmap_host_model_inst.read(p, f);
    check_val("program second half", {HMAP_PM_LO_PAD, pw[7:0]}, f);
    hmap_host_model_inst.read(p, f);
    check_val("program next word", x, f);
    $display("test program split done");
    hmap_host_model_inst.latch(16'h4010);
    hmap_host_model_inst.write(x ^ 16'h5A5A, 1'b0);
    hmap_host_model_inst.latch(16'h7FE7);
    hmap_host_model_inst.write(16'h4000, 1'b0);
    check_val("mode by host", 16'h0001, {15'h0000, mode});
    check_val("overlay by host", 16'h4000, ovl);
    hmap_host_model_inst.latch(16'h4010);
    hmap_host_model_inst.read(p, f);
    check_val("prior only word", x, p);
    check_val("prior only old", x, f);
    hmap_host_model_inst.read(p, f);
    check_val("prior only stored", x ^ 16'h5A5A, f);
    core_we = 1'b1;
    core_d = 16'h1234;
    @(negedge i_clock);
    core_we = 1'b0;
    @(negedge i_clock);
    check_val("mode by core", 16'h0000, {15'h0000, mode});
    check_val("overlay by core", 16'h1234, ovl);
    hmap_host_model_inst.latch(16'h7FE7);
    hmap_host_model_inst.read(p, f);
    check_val("overlay read by host", 16'h1234, f);
    $display("test prior only mode done");
    test_done;
  end
endmodule
